// ==== hdl/ea_gen_pkg.sv ====
// Constants and types shared by the effective address generator.
// Assumes one 100 MHz processor clock and a synchronous active-high reset.
package ea_gen_pkg;
    localparam int ADDR_W = 32;
    localparam int REG_COUNT = 8;
    localparam logic [31:0] ADDR_RESET = 32'h0000_0000;
    localparam logic [2:0] SPACE_RESET = 3'h0;

    // Gray-coded along the listed order
    typedef enum logic [3:0] {
        MODE_DREG = 4'h0,
        MODE_AREG = 4'h1,
        MODE_AIND = 4'h3,
        MODE_AIND_D16 = 4'h2,
        MODE_AIND_IDX8 = 4'h6,
        MODE_AIND_IDXBD = 4'h7,
        MODE_MEM_POST = 4'h5,
        MODE_MEM_PRE = 4'h4,
        MODE_PC_D16 = 4'hC,
        MODE_PC_IDX8 = 4'hD,
        MODE_PC_IDXBD = 4'hF,
        MODE_PC_MEM_POST = 4'hE,
        MODE_PC_MEM_PRE = 4'hA,
        MODE_ABS_W = 4'hB,
        MODE_ABS_L = 4'h9,
        MODE_IMM = 4'h8
    } mode_type;

    typedef enum logic [1:0] {
        DISP_NONE = 2'h0,
        DISP_WORD = 2'h1,
        DISP_LONG = 2'h2
    } disp_size_type;

    typedef enum logic [1:0] {
        IMM_BYTE = 2'h0,
        IMM_WORD = 2'h1,
        IMM_LONG = 2'h2
    } imm_size_type;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_FETCH = 2'h1,
        ST_SUSPEND = 2'h3
    } state_type;
endpackage

// ==== hdl/index_if.sv ====
// Index operand path between the address generator and its scaler.
// Purely combinational; no clock travels on it.
`timescale 1ns/100ps
`default_nettype none
interface index_if;
    logic [31:0] raw;
    logic long_sel;
    logic [1:0] scale;
    logic [31:0] scaled;
    modport user (output raw, output long_sel, output scale, input scaled);
    modport scaler (input raw, input long_sel, input scale, output scaled);
endinterface
`default_nettype wire

// ==== hdl/index_scaler.sv ====
// Sizes and scales an index register value.
// Assumes the caller registers the result; this path is combinational.
`timescale 1ns/100ps
`default_nettype none
module index_scaler (
    // Index path
    index_if.scaler port
);
    logic [31:0] sized;

    always_comb begin
        sized = port.long_sel ? port.raw : {{16{port.raw[15]}}, port.raw[15:0]};
        port.scaled = sized << port.scale;
    end
endmodule // index_scaler
`default_nettype wire

// ==== hdl/effective_address_generator.sv ====
// Effective address generator: register, indexed, memory indirect and PC-relative forms.
// Assumes the decoder holds request fields while req_valid is high and the bus unit
// answers each fetch with one-cycle fetch_ack or fetch_berr.
// Notes on behaviour
// - Short 8/16-bit displacement is sign-extended and added
// - Index is scaled by 1, 2, 4 or 8
// - Index is word or long, any register
// - Optional 16/32-bit signed base displacement
// - Outer displacement added after the indirect fetch
// - Indirect fetch long word becomes new base
// - Immediate operand sized 8, 16 or 32 bits
// - Register number 0 to 7 selects register
// - PC plus sign-extended 16-bit displacement
// - 32-bit address with one of eight spaces
// - Bus error suspends and traps to handler
// - Resume reruns faulted cycle when required
`timescale 1ns/100ps
`default_nettype none
module effective_address_generator (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Decoder request
    input wire logic req_valid,
    output logic req_ready,
    input wire ea_gen_pkg::mode_type mode,
    input wire logic [2:0] data_reg_sel,
    input wire logic [2:0] addr_reg_sel,
    input wire logic index_is_addr,
    input wire logic [2:0] index_reg_sel,
    input wire logic index_long,
    input wire logic [1:0] index_scale,
    input wire logic [7:0] short_disp_byte,
    input wire logic [15:0] short_disp_word,
    input wire logic [31:0] base_disp,
    input wire ea_gen_pkg::disp_size_type base_disp_size,
    input wire logic [31:0] outer_disp,
    input wire ea_gen_pkg::disp_size_type outer_disp_size,
    input wire logic [31:0] imm_data,
    input wire ea_gen_pkg::imm_size_type imm_size,
    input wire logic [2:0] space,
    input wire logic [31:0] pc,
    // Register file contents
    input wire logic [7:0][31:0] data_regs,
    input wire logic [7:0][31:0] addr_regs,
    // Result
    output logic ea_valid,
    output logic [31:0] ea_addr,
    output logic [2:0] ea_space,
    output logic operand_valid,
    output logic [31:0] operand,
    // Bus unit
    output logic fetch_req,
    output logic [31:0] fetch_addr,
    output logic [2:0] fetch_space,
    input wire logic fetch_ack,
    input wire logic fetch_berr,
    input wire logic [31:0] fetch_data,
    // Exception handling
    output logic bus_error_trap,
    output logic suspended,
    input wire logic resume_valid,
    input wire logic resume_rerun,
    input wire logic [31:0] resume_data
);
    initial begin
        if (ea_gen_pkg::ADDR_W != 32 || ea_gen_pkg::REG_COUNT != 8) begin
            $error("Address generator serves only 32-bit addresses and eight registers");
        end
    end

    ea_gen_pkg::state_type state_reg, state_next;
    logic req_ready_reg, req_ready_next;
    logic ea_valid_reg, ea_valid_next;
    logic [31:0] ea_addr_reg, ea_addr_next;
    logic [2:0] ea_space_reg, ea_space_next;
    logic operand_valid_reg, operand_valid_next;
    logic [31:0] operand_reg, operand_next;
    logic fetch_req_reg, fetch_req_next;
    logic [31:0] fetch_addr_reg, fetch_addr_next;
    logic [31:0] post_add_reg, post_add_next;
    logic trap_reg, trap_next;
    logic suspended_reg, suspended_next;

    logic accept;
    logic pc_mode;
    logic [31:0] base_val, sext8, sext16, bd_val, od_val, idx_raw, scaled;
    index_if idx ();

    assign accept = req_valid && req_ready_reg;
    assign idx_raw = index_is_addr ? addr_regs[index_reg_sel] : data_regs[index_reg_sel];
    assign idx.raw = idx_raw;
    assign idx.long_sel = index_long;
    assign idx.scale = index_scale;
    assign scaled = idx.scaled;

    index_scaler scaler_inst (
        .port(idx)
    );

    always_comb begin
        pc_mode = (mode == ea_gen_pkg::MODE_PC_D16) || (mode == ea_gen_pkg::MODE_PC_IDX8)
            || (mode == ea_gen_pkg::MODE_PC_IDXBD) || (mode == ea_gen_pkg::MODE_PC_MEM_POST)
            || (mode == ea_gen_pkg::MODE_PC_MEM_PRE);
        base_val = pc_mode ? pc : addr_regs[addr_reg_sel];
        sext8 = {{24{short_disp_byte[7]}}, short_disp_byte};
        sext16 = {{16{short_disp_word[15]}}, short_disp_word};
        case (base_disp_size)
            ea_gen_pkg::DISP_WORD: bd_val = {{16{base_disp[15]}}, base_disp[15:0]};
            ea_gen_pkg::DISP_LONG: bd_val = base_disp;
            default: bd_val = 32'h0000_0000;
        endcase
        case (outer_disp_size)
            ea_gen_pkg::DISP_WORD: od_val = {{16{outer_disp[15]}}, outer_disp[15:0]};
            ea_gen_pkg::DISP_LONG: od_val = outer_disp;
            default: od_val = 32'h0000_0000;
        endcase
    end

    always_comb begin
        state_next = state_reg;
        ea_valid_next = 1'b0;
        ea_addr_next = ea_addr_reg;
        ea_space_next = ea_space_reg;
        operand_valid_next = 1'b0;
        operand_next = operand_reg;
        fetch_req_next = fetch_req_reg;
        fetch_addr_next = fetch_addr_reg;
        post_add_next = post_add_reg;
        trap_next = 1'b0;
        case (state_reg)
            ea_gen_pkg::ST_IDLE: begin
                if (accept) begin
                    ea_space_next = space;
                    ea_valid_next = 1'b1;
                    case (mode)
                        ea_gen_pkg::MODE_DREG: begin
                            ea_valid_next = 1'b0;
                            operand_valid_next = 1'b1;
                            operand_next = data_regs[data_reg_sel];
                        end
                        ea_gen_pkg::MODE_AREG: begin
                            ea_valid_next = 1'b0;
                            operand_valid_next = 1'b1;
                            operand_next = addr_regs[addr_reg_sel];
                        end
                        ea_gen_pkg::MODE_IMM: begin
                            ea_valid_next = 1'b0;
                            operand_valid_next = 1'b1;
                            case (imm_size)
                                ea_gen_pkg::IMM_BYTE: operand_next = {24'h00_0000, imm_data[7:0]};
                                ea_gen_pkg::IMM_WORD: operand_next = {16'h0000, imm_data[15:0]};
                                default: operand_next = imm_data;
                            endcase
                        end
                        ea_gen_pkg::MODE_AIND: ea_addr_next = base_val;
                        ea_gen_pkg::MODE_AIND_D16, ea_gen_pkg::MODE_PC_D16: ea_addr_next = base_val + sext16;
                        ea_gen_pkg::MODE_AIND_IDX8, ea_gen_pkg::MODE_PC_IDX8: begin
                            ea_addr_next = base_val + sext8 + scaled;
                        end
                        ea_gen_pkg::MODE_AIND_IDXBD, ea_gen_pkg::MODE_PC_IDXBD: begin
                            ea_addr_next = base_val + bd_val + scaled;
                        end
                        ea_gen_pkg::MODE_MEM_PRE, ea_gen_pkg::MODE_PC_MEM_PRE: begin
                            ea_valid_next = 1'b0;
                            fetch_req_next = 1'b1;
                            fetch_addr_next = base_val + bd_val + scaled;
                            post_add_next = od_val;
                            state_next = ea_gen_pkg::ST_FETCH;
                        end
                        ea_gen_pkg::MODE_MEM_POST, ea_gen_pkg::MODE_PC_MEM_POST: begin
                            ea_valid_next = 1'b0;
                            fetch_req_next = 1'b1;
                            fetch_addr_next = base_val + bd_val;
                            post_add_next = scaled + od_val;
                            state_next = ea_gen_pkg::ST_FETCH;
                        end
                        ea_gen_pkg::MODE_ABS_W: ea_addr_next = sext16;
                        default: ea_addr_next = base_disp;
                    endcase
                end
            end
            ea_gen_pkg::ST_FETCH: begin
                if (fetch_berr) begin
                    fetch_req_next = 1'b0;
                    trap_next = 1'b1;
                    state_next = ea_gen_pkg::ST_SUSPEND;
                end else if (fetch_ack) begin
                    fetch_req_next = 1'b0;
                    ea_addr_next = fetch_data + post_add_reg;
                    ea_valid_next = 1'b1;
                    state_next = ea_gen_pkg::ST_IDLE;
                end
            end
            ea_gen_pkg::ST_SUSPEND: begin
                if (resume_valid && resume_rerun) begin
                    fetch_req_next = 1'b1;
                    state_next = ea_gen_pkg::ST_FETCH;
                end else if (resume_valid) begin
                    ea_addr_next = resume_data + post_add_reg;
                    ea_valid_next = 1'b1;
                    state_next = ea_gen_pkg::ST_IDLE;
                end
            end
            default: state_next = ea_gen_pkg::ST_IDLE;
        endcase
        req_ready_next = (state_next == ea_gen_pkg::ST_IDLE);
        suspended_next = (state_next == ea_gen_pkg::ST_SUSPEND);
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_reg <= ea_gen_pkg::ST_IDLE;
            req_ready_reg <= 1'b0;
            ea_valid_reg <= 1'b0;
            ea_addr_reg <= ea_gen_pkg::ADDR_RESET;
            ea_space_reg <= ea_gen_pkg::SPACE_RESET;
            operand_valid_reg <= 1'b0;
            operand_reg <= ea_gen_pkg::ADDR_RESET;
            fetch_req_reg <= 1'b0;
            fetch_addr_reg <= ea_gen_pkg::ADDR_RESET;
            post_add_reg <= ea_gen_pkg::ADDR_RESET;
            trap_reg <= 1'b0;
            suspended_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            req_ready_reg <= req_ready_next;
            ea_valid_reg <= ea_valid_next;
            ea_addr_reg <= ea_addr_next;
            ea_space_reg <= ea_space_next;
            operand_valid_reg <= operand_valid_next;
            operand_reg <= operand_next;
            fetch_req_reg <= fetch_req_next;
            fetch_addr_reg <= fetch_addr_next;
            post_add_reg <= post_add_next;
            trap_reg <= trap_next;
            suspended_reg <= suspended_next;
        end
    end

    assign req_ready = req_ready_reg;
    assign ea_valid = ea_valid_reg;
    assign ea_addr = ea_addr_reg;
    assign ea_space = ea_space_reg;
    assign operand_valid = operand_valid_reg;
    assign operand = operand_reg;
    assign fetch_req = fetch_req_reg;
    assign fetch_addr = fetch_addr_reg;
    assign fetch_space = ea_space_reg;
    assign bus_error_trap = trap_reg;
    assign suspended = suspended_reg;

    // Independent reference sums for checking, not using the scaler
    logic [31:0] chk_d16, chk_idx8_l8, chk_idx8_w1, chk_pc16, chk_dreg;
    assign chk_d16 = addr_regs[addr_reg_sel] + {{16{short_disp_word[15]}}, short_disp_word};
    assign chk_idx8_l8 = addr_regs[addr_reg_sel] + {{24{short_disp_byte[7]}}, short_disp_byte} + {idx_raw[28:0], 3'h0};
    assign chk_idx8_w1 = addr_regs[addr_reg_sel] + {{24{short_disp_byte[7]}}, short_disp_byte}
        + {{16{idx_raw[15]}}, idx_raw[15:0]};
    assign chk_pc16 = pc + {{16{short_disp_word[15]}}, short_disp_word};
    assign chk_dreg = data_regs[data_reg_sel];

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    short_disp_a: assert property (accept && mode == ea_gen_pkg::MODE_AIND_D16
        |=> ea_valid && ea_addr == $past(chk_d16)) else $error("short displacement sum wrong");
    scale_eight_a: assert property (accept && mode == ea_gen_pkg::MODE_AIND_IDX8 && index_long
        && index_scale == 2'h3 |=> ea_addr == $past(chk_idx8_l8)) else $error("scaled index wrong");
    word_index_a: assert property (accept && mode == ea_gen_pkg::MODE_AIND_IDX8 && !index_long
        && index_scale == 2'h0 |=> ea_addr == $past(chk_idx8_w1)) else $error("word index not extended");
    pre_fetch_a: assert property (accept && mode == ea_gen_pkg::MODE_MEM_PRE
        |=> fetch_req && !ea_valid && fetch_addr == $past(base_val) + $past(bd_val) + $past(scaled))
        else $error("preindexed fetch address wrong");
    outer_disp_a: assert property (state_reg == ea_gen_pkg::ST_FETCH && fetch_ack && !fetch_berr
        |=> ea_valid && !fetch_req && ea_addr == $past(fetch_data) + $past(post_add_reg))
        else $error("outer displacement not applied after fetch");
    fetch_hold_a: assert property (fetch_req && !fetch_ack && !fetch_berr
        |=> fetch_req && $stable(fetch_addr)) else $error("fetch request dropped");
    imm_byte_a: assert property (accept && mode == ea_gen_pkg::MODE_IMM && imm_size == ea_gen_pkg::IMM_BYTE
        |=> operand_valid && operand == ($past(imm_data) & 32'h0000_00FF)) else $error("byte immediate wrong");
    dreg_pick_a: assert property (accept && mode == ea_gen_pkg::MODE_DREG
        |=> operand_valid && operand == $past(chk_dreg)) else $error("data register select wrong");
    pc_rel_a: assert property (accept && mode == ea_gen_pkg::MODE_PC_D16
        |=> ea_addr == $past(chk_pc16)) else $error("PC relative sum wrong");
    space_carry_a: assert property (accept |=> ea_space == $past(space)
        && fetch_space == ea_space) else $error("address space not carried");
    berr_trap_a: assert property (state_reg == ea_gen_pkg::ST_FETCH && fetch_berr
        |=> bus_error_trap && suspended && !fetch_req ##1 !bus_error_trap) else $error("bus error not trapped");
    rerun_a: assert property (suspended && resume_valid && resume_rerun
        |=> fetch_req && fetch_addr == $past(fetch_addr)) else $error("faulted cycle not rerun");

    cover_post_c: cover property (accept && mode == ea_gen_pkg::MODE_MEM_POST ##[1:20] ea_valid);
    cover_berr_c: cover property (bus_error_trap ##[1:50] (suspended && resume_valid && resume_rerun));
    cover_resume_c: cover property (suspended && resume_valid && !resume_rerun ##1 ea_valid);
endmodule // effective_address_generator
`default_nettype wire

// ==== tb/ea_bus_model.sv ====
// Bus unit stand-in that answers the generator's long-word fetches.
// Assumes fetch_req is a registered level held until ack or berr.
`timescale 1ns/100ps
`default_nettype none
module ea_bus_model (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Fetch request
    input wire logic fetch_req,
    input wire logic [31:0] fetch_addr,
    // Bench controls
    input wire logic [3:0] delay,
    input wire logic berr_arm,
    // Answer
    output logic fetch_ack,
    output logic fetch_berr,
    output logic [31:0] fetch_data
);
    logic [3:0] wait_cnt;

    initial begin
        fetch_ack = 1'h0;
        fetch_berr = 1'h0;
        fetch_data = 32'h0;
        wait_cnt = 4'h0;
    end

    // Data is only meaningful with ack; it toggles otherwise so stale values never pass
    always @(posedge ref_clk) begin
        #1;
        fetch_data = ~fetch_data;
        if (rst || fetch_ack || fetch_berr) begin
            fetch_ack = 1'h0;
            fetch_berr = 1'h0;
            wait_cnt = 4'h0;
        end else if (fetch_req && wait_cnt >= delay) begin
            fetch_berr = berr_arm;
            fetch_ack = ~berr_arm;
            if (!berr_arm) begin
                fetch_data = ~{fetch_addr[15:0], fetch_addr[31:16]};
            end
        end else if (fetch_req) begin
            wait_cnt = wait_cnt + 4'h1;
        end
    end
endmodule // ea_bus_model
`default_nettype wire

// ==== tb/effective_address_generator_tb_top.sv ====
// Self-checking bench for the effective address generator.
// Assumes the bus model above and a 100 MHz clock; inputs move 1 ns after each edge.
`timescale 1ns/100ps
`default_nettype none
module effective_address_generator_tb_top;
    localparam int WATCHDOG_NS = 100000;
    logic ref_clk, rst, req_valid, index_is_addr, index_long, resume_valid, resume_rerun, berr_arm;
    logic [2:0] data_reg_sel, addr_reg_sel, index_reg_sel, space, ea_space, fetch_space;
    logic [1:0] index_scale;
    logic [7:0] short_disp_byte;
    logic [15:0] short_disp_word;
    logic [31:0] base_disp, outer_disp, imm_data, pc, resume_data, ea_addr, operand, fetch_addr, fetch_data;
    ea_gen_pkg::mode_type mode;
    ea_gen_pkg::disp_size_type base_disp_size, outer_disp_size;
    ea_gen_pkg::imm_size_type imm_size;
    logic [7:0][31:0] data_regs, addr_regs;
    logic [3:0] bus_delay;
    logic req_ready, ea_valid, operand_valid, fetch_req, fetch_ack, fetch_berr, bus_error_trap, suspended;
    int mismatches, n_compared;

    effective_address_generator dut (
        .ref_clk, .rst, .req_valid, .req_ready, .mode, .data_reg_sel, .addr_reg_sel,
        .index_is_addr, .index_reg_sel, .index_long, .index_scale, .short_disp_byte,
        .short_disp_word, .base_disp, .base_disp_size, .outer_disp, .outer_disp_size,
        .imm_data, .imm_size, .space, .pc, .data_regs, .addr_regs, .ea_valid, .ea_addr,
        .ea_space, .operand_valid, .operand, .fetch_req, .fetch_addr, .fetch_space,
        .fetch_ack, .fetch_berr, .fetch_data, .bus_error_trap, .suspended,
        .resume_valid, .resume_rerun, .resume_data);

    ea_bus_model bus (.ref_clk, .rst, .fetch_req, .fetch_addr, .delay(bus_delay), .berr_arm,
        .fetch_ack, .fetch_berr, .fetch_data);

    always #5 ref_clk = ~ref_clk;

    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic logic [31:0] sx16(input logic [15:0] v);
        return {{16{v[15]}}, v};
    endfunction

    function automatic logic [31:0] ds(input logic [31:0] v, input ea_gen_pkg::disp_size_type s);
        if (s == ea_gen_pkg::DISP_WORD) return sx16(v[15:0]);
        return (s == ea_gen_pkg::DISP_LONG) ? v : 32'h0;
    endfunction

    function automatic logic [31:0] ixv();
        logic [31:0] r;
        r = index_is_addr ? addr_regs[index_reg_sel] : data_regs[index_reg_sel];
        if (!index_long) r = sx16(r[15:0]);
        return r << index_scale;
    endfunction

    // Same word the bus model returns for a fetch address
    function automatic logic [31:0] fm(input logic [31:0] a);
        return ~{a[15:0], a[31:16]};
    endfunction

    task automatic take();
        int k;
        k = 0;
        // One idle edge so a dropped request is never raised again in the same step
        @(posedge ref_clk);
        #1;
        while (req_ready !== 1'h1 && k < 50) begin @(posedge ref_clk); #1; k++; end
        req_valid = 1'h1;
        @(posedge ref_clk);
        #1;
        req_valid = 1'h0;
    endtask

    task automatic wait_ea();
        int k;
        k = 0;
        while (ea_valid !== 1'h1 && k < 50) begin @(posedge ref_clk); #1; k++; end
    endtask

    // Plain forms must answer at the taking edge itself, checked 1 ns later
    task automatic go(input logic ind, input logic [31:0] fa, input logic [31:0] exp);
        take();
        if (ind) begin
            chk({fetch_req, req_ready}, 32'h2);
            chk(fetch_addr, fa);
            chk(fetch_space, space);
            wait_ea();
        end
        chk(ea_valid | operand_valid, 32'h1);
        chk(operand_valid ? operand : ea_addr, exp);
        chk(ea_space, space);
    endtask

    task automatic t_regs();
        for (int n = 0; n < 8; n++) begin
            space = 3'(n);
            data_reg_sel = 3'(n);
            addr_reg_sel = 3'(7 - n);
            mode = ea_gen_pkg::MODE_DREG;
            go(1'h0, 32'h0, data_regs[n]);
            mode = ea_gen_pkg::MODE_AREG;
            go(1'h0, 32'h0, addr_regs[7 - n]);
            mode = ea_gen_pkg::MODE_AIND;
            go(1'h0, 32'h0, addr_regs[7 - n]);
        end
        mode = ea_gen_pkg::MODE_IMM;
        imm_data = 32'hFEDC_BA98;
        imm_size = ea_gen_pkg::IMM_BYTE;
        go(1'h0, 32'h0, 32'h0000_0098);
        imm_size = ea_gen_pkg::IMM_WORD;
        go(1'h0, 32'h0, 32'h0000_BA98);
        imm_size = ea_gen_pkg::IMM_LONG;
        go(1'h0, 32'h0, 32'hFEDC_BA98);
    endtask

    task automatic t_disp();
        mode = ea_gen_pkg::MODE_AIND_D16;
        short_disp_word = 16'h8004;
        go(1'h0, 32'h0, addr_regs[addr_reg_sel] + 32'hFFFF_8004);
        mode = ea_gen_pkg::MODE_PC_D16;
        go(1'h0, 32'h0, pc + 32'hFFFF_8004);
        short_disp_word = 16'h7FFE;
        go(1'h0, 32'h0, pc + 32'h0000_7FFE);
        mode = ea_gen_pkg::MODE_ABS_W;
        short_disp_word = 16'hFFF0;
        go(1'h0, 32'h0, 32'hFFFF_FFF0);
        mode = ea_gen_pkg::MODE_ABS_L;
        base_disp = 32'hFFFF_FFFC;
        go(1'h0, 32'h0, 32'hFFFF_FFFC);
    endtask

    // Every scale, size and register bank, 8-bit and base displacement forms
    task automatic t_idx();
        logic [31:0] b;
        for (int i = 0; i < 16; i++) begin
            index_scale = 2'(i);
            index_long = i[2];
            index_is_addr = i[3];
            index_reg_sel = 3'(i + 3);
            short_disp_byte = 8'(8'h7E + i);
            b = i[0] ? pc : addr_regs[addr_reg_sel];
            mode = i[0] ? ea_gen_pkg::MODE_PC_IDX8 : ea_gen_pkg::MODE_AIND_IDX8;
            go(1'h0, 32'h0, b + {{24{short_disp_byte[7]}}, short_disp_byte} + ixv());
            base_disp = 32'h0123_9ABC;
            base_disp_size = ea_gen_pkg::disp_size_type'(2'(i % 3));
            mode = i[0] ? ea_gen_pkg::MODE_PC_IDXBD : ea_gen_pkg::MODE_AIND_IDXBD;
            go(1'h0, 32'h0, b + ds(base_disp, base_disp_size) + ixv());
        end
    endtask

    task automatic t_b2b();
        mode = ea_gen_pkg::MODE_AIND_D16;
        short_disp_word = 16'h8000;
        @(posedge ref_clk);
        #1;
        req_valid = 1'h1;
        @(posedge ref_clk);
        #1;
        chk({ea_valid, req_ready}, 32'h3);
        chk(ea_addr, addr_regs[addr_reg_sel] + 32'hFFFF_8000);
        short_disp_word = 16'h7FFF;
        @(posedge ref_clk);
        #1;
        req_valid = 1'h0;
        chk(ea_valid, 32'h1);
        chk(ea_addr, addr_regs[addr_reg_sel] + 32'h0000_7FFF);
    endtask

    task automatic t_mem();
        logic [31:0] fa;
        logic post;
        ea_gen_pkg::mode_type mt[4] = '{ea_gen_pkg::MODE_MEM_PRE, ea_gen_pkg::MODE_MEM_POST,
            ea_gen_pkg::MODE_PC_MEM_PRE, ea_gen_pkg::MODE_PC_MEM_POST};
        for (int i = 0; i < 12; i++) begin
            mode = mt[i % 4];
            post = i[0];
            bus_delay = 4'(i % 4);
            index_scale = 2'(i);
            index_long = i[1];
            index_is_addr = i[2];
            base_disp = 32'h8000_F000 + 32'(i);
            outer_disp = 32'h0001_C000 - 32'(i);
            base_disp_size = ea_gen_pkg::disp_size_type'(2'((i + 1) % 3));
            outer_disp_size = ea_gen_pkg::disp_size_type'(2'(i / 4));
            fa = (i % 4 >= 2) ? pc : addr_regs[addr_reg_sel];
            fa = fa + ds(base_disp, base_disp_size) + (post ? 32'h0 : ixv());
            go(1'h1, fa, fm(fa) + ds(outer_disp, outer_disp_size) + (post ? ixv() : 32'h0));
        end
    endtask

    // Fault, then rerun; fault again, then handler-supplied word
    task automatic t_berr();
        logic [31:0] fa;
        mode = ea_gen_pkg::MODE_MEM_POST;
        bus_delay = 4'h1;
        outer_disp_size = ea_gen_pkg::DISP_WORD;
        fa = addr_regs[addr_reg_sel] + ds(base_disp, base_disp_size);
        for (int r = 1; r >= 0; r--) begin
            berr_arm = 1'h1;
            take();
            while (bus_error_trap !== 1'h1 && fetch_req === 1'h1) begin @(posedge ref_clk); #1; end
            berr_arm = 1'h0;
            chk({bus_error_trap, suspended, fetch_req, req_ready}, 32'hC);
            @(posedge ref_clk);
            #1;
            chk({bus_error_trap, suspended, req_ready}, 32'h2);
            resume_valid = 1'h1;
            resume_rerun = 1'(r);
            resume_data = 32'h1357_9BDF;
            @(posedge ref_clk);
            #1;
            resume_valid = 1'h0;
            chk(suspended, 32'h0);
            if (r == 1) begin
                chk({fetch_req, fetch_addr[30:0]}, {1'h1, fa[30:0]});
                wait_ea();
            end
            chk(ea_valid, 32'h1);
            chk(ea_addr, (r == 1 ? fm(fa) : resume_data) + ixv() + sx16(outer_disp[15:0]));
        end
    endtask

    initial begin
        ref_clk = 1'h0;
        rst = 1'h1;
        {req_valid, index_is_addr, index_long, resume_valid, resume_rerun, berr_arm} = 6'h0;
        {data_reg_sel, addr_reg_sel, index_reg_sel, space, index_scale} = 14'h0;
        {short_disp_byte, short_disp_word} = 24'h0;
        {base_disp, outer_disp, imm_data, resume_data} = 128'h0;
        pc = 32'h0020_FF00;
        mode = ea_gen_pkg::MODE_DREG;
        base_disp_size = ea_gen_pkg::DISP_NONE;
        outer_disp_size = ea_gen_pkg::DISP_NONE;
        imm_size = ea_gen_pkg::IMM_BYTE;
        bus_delay = 4'h0;
        for (int n = 0; n < 8; n++) begin
            data_regs[n] = 32'h0012_F000 + 32'h0010_0011 * 32'(n);
            addr_regs[n] = 32'h4000_0100 + 32'h0000_9100 * 32'(n);
        end
        repeat (8) @(posedge ref_clk);
        #1;
        rst = 1'h0;
        t_regs();
        t_disp();
        t_idx();
        t_b2b();
        t_mem();
        t_berr();
        test_done();
    end

    initial begin
        #WATCHDOG_NS;
        mismatches++;
        test_done();
    end
endmodule // effective_address_generator_tb_top
`default_nettype wire
